/* verilog/fcr_config.v */
/*
  Configuration register logic of a serial NOR flash: the persistent
  and runtime configuration registers, their serial register commands
  and the internal configuration decoded from them.
  Assumes sclk, cs_n and si are pins from the host (mode 0, MSB first),
  and that rd_start, rd_next and rd_start_addr come from the read engine
  on mclk. Persistent storage is modelled by flops cleared only by por.
*/
// Notes on behaviour
// [RL1] persistent dummy code 1..14 literal, 1111 default, 0000 same as 1111
// [RL2] runtime bits 7:4 give dummy count for every fast read; after reset, until a runtime write, persistent bits 15:12 do
// [RL3] persistent bits 11:9 pick execute-in-place mode after power-on
// [RL4] persistent bits 8:6 pick driver: 90, 45, 20, 30 ohm
// [RL5] persistent bit 5 low runs all commands in double transfer rate
// [RL6] persistent bit 4 high enables hold or reset on data line three
// [RL7] persistent bit 3 low accepts quad 4-4-4 commands
// [RL8] persistent bit 2 low accepts dual 2-2-2 commands
// [RL9] both bits low means quad wins over dual
// [RL10] persistent bit 1 low picks highest segment, high picks lowest
// [RL11] persistent bit 0 low means four address bytes, high three
// [RL12] host must set enough dummy cycles for its clock rate
// [RL13] runtime write copies into internal configuration; separate readback
// [RL14] runtime bit 3 low enables execute-in-place, high disables
// [RL15] wrap codes 00, 01, 10 wrap in aligned 16, 32, 64 bytes
// [RL16] wrap code 11 counts on through the whole array
// [RL17] every reset reloads internal configuration from persistent register
// [RL18] in four-byte mode the segment register is ignored
// [RL19] runtime register holds its defaults after reset until written
`include "fcr_map.vh"

module fcr_config #(
  parameter ADDR_W = 26,
  parameter [3:0] DUMMY_DEFAULT = `FCR_DUMMY_DEFAULT
) (
  // clock, reset and power-on reset
  input wire mclk,
  input wire reset,
  input wire por,
  // serial link pins
  input wire sclk,
  input wire cs_n,
  input wire si,
  output wire so,
  output wire so_oe_n,
  // read engine on mclk
  input wire rd_start,
  input wire [31:0] rd_start_addr,
  input wire rd_next,
  output wire [ADDR_W-1:0] rd_addr,
  // decoded configuration
  output wire [3:0] dummy_cycles,
  output wire [2:0] execute_in_place_mode,
  output wire eip_enable,
  output wire [2:0] drive_sel,
  output wire dtr_enable,
  output wire data_line_three_func_en,
  output wire quad_enable,
  output wire dual_enable,
  output wire four_byte_addr,
  output wire [1:0] segment_sel,
  output wire [1:0] wrap_code
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_OPC = 3'h1;
  localparam [2:0] ST_WDATA = 3'h2;
  localparam [2:0] ST_RDATA = 3'h3;
  localparam [2:0] ST_IGNORE = 3'h4;

  // dummy count decode shared by both registers
  function [3:0] dec_dummy;
    input [3:0] code;
    begin
      if (code == `FCR_DUMMY_ZERO || code == `FCR_DUMMY_DEFCODE)
        dec_dummy = DUMMY_DEFAULT;
      else
        dec_dummy = code;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detect

  wire [2:0] pin_lvl;
  wire sclk_s;
  wire cs_n_s;
  wire si_s;
  reg sclk_d_ff;
  reg cs_n_d_ff;

  fcr_sync #(
    .WIDTH(3),
    .INIT(3'h2)
  ) u_sync (
    .mclk(mclk),
    .reset(reset),
    .pin_in({sclk, cs_n, si}),
    .level_out(pin_lvl)
  );

  assign sclk_s = pin_lvl[2];
  assign cs_n_s = pin_lvl[1];
  assign si_s = pin_lvl[0];

  // delayed copies of synchronised levels
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      sclk_d_ff <= 1'b0;
      cs_n_d_ff <= 1'b1;
    end else begin
      sclk_d_ff <= sclk_s;
      cs_n_d_ff <= cs_n_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d_ff;
  wire sclk_fall = ~sclk_s & sclk_d_ff;
  wire cs_fall = ~cs_n_s & cs_n_d_ff;
  wire cs_rise = cs_n_s & ~cs_n_d_ff;

  //////////////////////////////////////////////////////////////////////
  // serial command engine

  reg [2:0] state_ff;
  reg [4:0] bit_cnt_ff;
  reg [15:0] in_sh_ff;
  reg [15:0] out_sh_ff;
  reg wr_persist_ff;
  reg so_ff;
  reg so_oe_n_ff;
  reg [15:0] persist_ff;
  reg [7:0] runtime_ff;
  reg runtime_wr_ff;

  wire [7:0] opc_now = {in_sh_ff[6:0], si_s};
  wire [4:0] cnt_inc = (bit_cnt_ff == 5'h1f) ? bit_cnt_ff :
                       bit_cnt_ff + 5'h01;

  // frames start on cs fall, end on cs rise at any point
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 5'h00;
      in_sh_ff <= 16'h0000;
      out_sh_ff <= 16'h0000;
      wr_persist_ff <= 1'b0;
      so_ff <= 1'b0;
      so_oe_n_ff <= 1'b1;
    end else if (cs_rise || cs_n_s) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 5'h00;
      so_oe_n_ff <= 1'b1;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (cs_fall) begin
            state_ff <= ST_OPC;
            bit_cnt_ff <= 5'h00;
          end
        end
        ST_OPC: begin
          if (sclk_rise) begin
            in_sh_ff <= {in_sh_ff[14:0], si_s};
            bit_cnt_ff <= cnt_inc;
            if (cnt_inc == `FCR_OPC_BITS) begin
              case (opc_now)
                `FCR_OP_WR_PERSIST: begin
                  state_ff <= ST_WDATA;
                  wr_persist_ff <= 1'b1;
                end
                `FCR_OP_WR_RUNTIME: begin
                  state_ff <= ST_WDATA;
                  wr_persist_ff <= 1'b0;
                end
                // [RL13] separate readback command
                `FCR_OP_RD_PERSIST: begin
                  state_ff <= ST_RDATA;
                  out_sh_ff <= persist_ff;
                end
                `FCR_OP_RD_RUNTIME: begin
                  state_ff <= ST_RDATA;
                  out_sh_ff <= {runtime_ff, runtime_ff};
                end
                default: state_ff <= ST_IGNORE;
              endcase
            end
          end
        end
        ST_WDATA: begin
          if (sclk_rise) begin
            in_sh_ff <= {in_sh_ff[14:0], si_s};
            bit_cnt_ff <= cnt_inc;
          end
        end
        ST_RDATA: begin
          // data shifts out on falling edges, repeating the register
          if (sclk_fall) begin
            so_ff <= out_sh_ff[15];
            so_oe_n_ff <= 1'b0;
            out_sh_ff <= {out_sh_ff[14:0], out_sh_ff[15]};
          end
        end
        ST_IGNORE: state_ff <= ST_IGNORE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // a write commits only on a frame of exactly the right length
  wire commit_persist = cs_rise && state_ff == ST_WDATA &&
                        wr_persist_ff && bit_cnt_ff == `FCR_PERSIST_END;
  wire commit_runtime = cs_rise && state_ff == ST_WDATA &&
                        !wr_persist_ff && bit_cnt_ff == `FCR_RUNTIME_END;

  //////////////////////////////////////////////////////////////////////
  // register storage

  // persistent register survives reset; only por clears it
  always @(posedge mclk or posedge por) begin
    if (por)
      persist_ff <= `FCR_PERSIST_RESET;
    else if (commit_persist)
      persist_ff <= in_sh_ff;
  end

  // [RL19] runtime defaults until written
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      runtime_ff <= `FCR_RUNTIME_RESET;
      runtime_wr_ff <= 1'b0;
    end else begin
      runtime_wr_ff <= commit_runtime;
      if (commit_runtime) begin
        runtime_ff <= in_sh_ff[7:0];
        // reserved bit always reads zero
        runtime_ff[`FCR_RC_RSVD] <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // internal configuration

  reg load_persist_ff;
  reg [3:0] icr_dummy_ff;
  reg [2:0] icr_eip_mode_ff;
  reg icr_eip_en_ff;
  reg [2:0] icr_drv_ff;
  reg icr_dtr_n_ff;
  reg icr_hold_ff;
  reg icr_quad_n_ff;
  reg icr_dual_n_ff;
  reg icr_seg_low_ff;
  reg icr_addr3_ff;
  reg [1:0] icr_wrap_ff;
  reg [1:0] ext_seg_ff;

  // reset cannot sample a register, so reload one cycle after release
  always @(posedge mclk or posedge reset) begin
    if (reset)
      load_persist_ff <= 1'b1;
    else
      load_persist_ff <= 1'b0;
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      icr_dummy_ff <= `FCR_DUMMY_DEFCODE;
      icr_eip_mode_ff <= `FCR_EIP_NONE;
      icr_eip_en_ff <= 1'b0;
      icr_drv_ff <= `FCR_DRV_30;
      icr_dtr_n_ff <= 1'b1;
      icr_hold_ff <= 1'b1;
      icr_quad_n_ff <= 1'b1;
      icr_dual_n_ff <= 1'b1;
      icr_seg_low_ff <= 1'b1;
      icr_addr3_ff <= 1'b1;
      icr_wrap_ff <= `FCR_WRAP_CONT;
      ext_seg_ff <= `FCR_SEG_LOW;
    end else if (load_persist_ff) begin
      // [RL17] reload from persistent register
      icr_dummy_ff <= persist_ff[`FCR_PC_DUMMY_HI:`FCR_PC_DUMMY_LO];
      // [RL3] power-on execute-in-place
      icr_eip_mode_ff <= persist_ff[`FCR_PC_EIP_HI:`FCR_PC_EIP_LO];
      icr_eip_en_ff <= persist_ff[`FCR_PC_EIP_HI:`FCR_PC_EIP_LO] !=
                       `FCR_EIP_NONE;
      icr_drv_ff <= persist_ff[`FCR_PC_DRV_HI:`FCR_PC_DRV_LO];
      icr_dtr_n_ff <= persist_ff[`FCR_PC_DTR];
      icr_hold_ff <= persist_ff[`FCR_PC_HOLD];
      icr_quad_n_ff <= persist_ff[`FCR_PC_QUAD];
      icr_dual_n_ff <= persist_ff[`FCR_PC_DUAL];
      icr_seg_low_ff <= persist_ff[`FCR_PC_SEG];
      icr_addr3_ff <= persist_ff[`FCR_PC_ADDR];
      // wrap is runtime only; runtime reset value applies
      icr_wrap_ff <= runtime_ff[`FCR_RC_WRAP_HI:`FCR_RC_WRAP_LO];
      // [RL10] default segment from bit 1
      ext_seg_ff <= persist_ff[`FCR_PC_SEG] ? `FCR_SEG_LOW :
                    `FCR_SEG_HIGH;
    end else if (runtime_wr_ff) begin
      // [RL13] copy after runtime write
      icr_dummy_ff <= runtime_ff[`FCR_RC_DUMMY_HI:`FCR_RC_DUMMY_LO];
      // [RL14] low bit enables
      icr_eip_en_ff <= ~runtime_ff[`FCR_RC_EIP];
      icr_wrap_ff <= runtime_ff[`FCR_RC_WRAP_HI:`FCR_RC_WRAP_LO];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // registered decoded outputs

  reg [3:0] dummy_out_ff;
  reg [2:0] eip_mode_out_ff;
  reg eip_en_out_ff;
  reg [2:0] drv_out_ff;
  reg dtr_out_ff;
  reg hold_out_ff;
  reg quad_out_ff;
  reg dual_out_ff;
  reg addr4_out_ff;
  reg [1:0] seg_out_ff;
  reg [1:0] wrap_out_ff;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      dummy_out_ff <= DUMMY_DEFAULT;
      eip_mode_out_ff <= `FCR_EIP_NONE;
      eip_en_out_ff <= 1'b0;
      drv_out_ff <= `FCR_DRV_30;
      dtr_out_ff <= 1'b0;
      hold_out_ff <= 1'b1;
      quad_out_ff <= 1'b0;
      dual_out_ff <= 1'b0;
      addr4_out_ff <= 1'b0;
      seg_out_ff <= `FCR_SEG_LOW;
      wrap_out_ff <= `FCR_WRAP_CONT;
    end else begin
      // [RL1] [RL2] shared dummy decode
      dummy_out_ff <= dec_dummy(icr_dummy_ff);
      eip_mode_out_ff <= icr_eip_mode_ff;
      eip_en_out_ff <= icr_eip_en_ff;
      // [RL4] even codes reserved, fall back to 30 ohm
      drv_out_ff <= icr_drv_ff[0] ? icr_drv_ff : `FCR_DRV_30;
      // [RL5] low enables dtr
      dtr_out_ff <= ~icr_dtr_n_ff;
      // [RL6] data line three function
      hold_out_ff <= icr_hold_ff;
      // [RL7] quad on low
      quad_out_ff <= ~icr_quad_n_ff;
      // [RL8] [RL9] dual only when quad is off
      dual_out_ff <= ~icr_dual_n_ff & icr_quad_n_ff;
      // [RL11] address byte count
      addr4_out_ff <= ~icr_addr3_ff;
      seg_out_ff <= ext_seg_ff;
      wrap_out_ff <= icr_wrap_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read address sequencer

  reg [ADDR_W-1:0] rd_addr_ff;
  wire [ADDR_W-1:0] wrap_next;
  wire [ADDR_W-1:0] start_3b;

  // [RL18] segment bits only in three-byte mode
  assign start_3b = {ext_seg_ff, rd_start_addr[23:0]};

  // [RL15] [RL16] block wrap or continuous
  fcr_wrap_addr #(
    .ADDR_W(ADDR_W)
  ) u_wrap (
    .wrap_code(icr_wrap_ff),
    .cur_addr(rd_addr_ff),
    .next_addr(wrap_next)
  );

  always @(posedge mclk or posedge reset) begin
    if (reset)
      rd_addr_ff <= {ADDR_W{1'b0}};
    else if (rd_start)
      rd_addr_ff <= icr_addr3_ff ? start_3b :
                    rd_start_addr[ADDR_W-1:0];
    else if (rd_next)
      rd_addr_ff <= wrap_next;
  end

  //////////////////////////////////////////////////////////////////////
  // outputs

  assign so = so_ff;
  assign so_oe_n = so_oe_n_ff;
  assign rd_addr = rd_addr_ff;
  assign dummy_cycles = dummy_out_ff;
  assign execute_in_place_mode = eip_mode_out_ff;
  assign eip_enable = eip_en_out_ff;
  assign drive_sel = drv_out_ff;
  assign dtr_enable = dtr_out_ff;
  assign data_line_three_func_en = hold_out_ff;
  assign quad_enable = quad_out_ff;
  assign dual_enable = dual_out_ff;
  assign four_byte_addr = addr4_out_ff;
  assign segment_sel = seg_out_ff;
  assign wrap_code = wrap_out_ff;

endmodule // fcr_config

/* verilog/fcr_map.vh */
/*
  Constants of the flash configuration register block: command codes,
  field positions, reset values and decode codes.
  Assumes inclusion by its bare name from the design files and the bench.
*/
`ifndef FCR_MAP_VH
`define FCR_MAP_VH

// register command codes, one byte each
`define FCR_OP_RD_PERSIST 8'hb5
`define FCR_OP_WR_PERSIST 8'hb1
`define FCR_OP_RD_RUNTIME 8'h85
`define FCR_OP_WR_RUNTIME 8'h81

// serial frame lengths in bits
`define FCR_OPC_BITS 5'h08
`define FCR_PERSIST_END 5'h18
`define FCR_RUNTIME_END 5'h10

// persistent_config field positions
`define FCR_PC_DUMMY_HI 15
`define FCR_PC_DUMMY_LO 12
`define FCR_PC_EIP_HI 11
`define FCR_PC_EIP_LO 9
`define FCR_PC_DRV_HI 8
`define FCR_PC_DRV_LO 6
`define FCR_PC_DTR 5
`define FCR_PC_HOLD 4
`define FCR_PC_QUAD 3
`define FCR_PC_DUAL 2
`define FCR_PC_SEG 1
`define FCR_PC_ADDR 0

// runtime_config field positions
`define FCR_RC_DUMMY_HI 7
`define FCR_RC_DUMMY_LO 4
`define FCR_RC_EIP 3
`define FCR_RC_RSVD 2
`define FCR_RC_WRAP_HI 1
`define FCR_RC_WRAP_LO 0

// reset values
`define FCR_PERSIST_RESET 16'hffff
`define FCR_RUNTIME_RESET 8'hfb

// field codes
`define FCR_DUMMY_ZERO 4'h0
`define FCR_DUMMY_DEFCODE 4'hf
`define FCR_DUMMY_DEFAULT 4'h8
`define FCR_EIP_NONE 3'h7
`define FCR_DRV_90 3'h1
`define FCR_DRV_45 3'h3
`define FCR_DRV_20 3'h5
`define FCR_DRV_30 3'h7
`define FCR_WRAP_16 2'h0
`define FCR_WRAP_32 2'h1
`define FCR_WRAP_64 2'h2
`define FCR_WRAP_CONT 2'h3
`define FCR_SEG_LOW 2'h0
`define FCR_SEG_HIGH 2'h3

`endif

/* verilog/fcr_sync.v */
/*
  Two-flop level synchroniser for a bundle of pin inputs.
  Assumes each bit is an independent level; no word coherence.
*/
module fcr_sync #(
  parameter WIDTH = 3,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  // clock and reset
  input wire mclk,
  input wire reset,
  // pins in and synchronised levels out
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] level_out
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // first stage is read only by the second
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      meta_ff <= INIT;
      sync_ff <= INIT;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  assign level_out = sync_ff;

endmodule // fcr_sync

/* verilog/fcr_wrap_addr.v */
/*
  Next read address for a sequential read, honouring the wrap length.
  Assumes the caller registers the result; purely combinational.
*/
`include "fcr_map.vh"

module fcr_wrap_addr #(
  parameter ADDR_W = 26
) (
  // wrap code and current address
  input wire [1:0] wrap_code,
  input wire [ADDR_W-1:0] cur_addr,
  // address of the next byte
  output reg [ADDR_W-1:0] next_addr
);

  reg [ADDR_W-1:0] inc_addr;
  reg [ADDR_W-1:0] blk_mask;

  // in-block bits advance, block bits stay put
  always @* begin
    inc_addr = cur_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
    case (wrap_code)
      `FCR_WRAP_16: blk_mask = {{(ADDR_W-4){1'b0}}, 4'hf};
      `FCR_WRAP_32: blk_mask = {{(ADDR_W-5){1'b0}}, 5'h1f};
      `FCR_WRAP_64: blk_mask = {{(ADDR_W-6){1'b0}}, 6'h3f};
      default: blk_mask = {ADDR_W{1'b1}};
    endcase
    next_addr = (cur_addr & ~blk_mask) | (inc_addr & blk_mask);
  end

endmodule // fcr_wrap_addr

/* bench/fcr_host.sv */
/*
  Host serial controller model that drives the register link pins.
  Assumes mode 0 framing, msb first, and a 125 ns serial clock that
  stands still between frames.
*/
module fcr_host (
  // link pins toward the device
  output logic sclk,
  output logic cs_n,
  output logic si,
  // answer from the device
  input wire so,
  input wire so_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  // dummy count choice
  // the host only moves registers here and never issues a fast read,
  // so no dummy count is ever too short for this clock
  task automatic xfer(input int n, input logic [23:0] bits,
                      output logic [23:0] rx);
    rx = 24'h0;
    cs_n = 1'b0;
    for (int k = n - 1; k >= 0; k--) begin
      si = bits[k];
      #62.5 sclk = 1'b1;
      // an undriven answer must never pass for data
      rx = {rx[22:0], so_oe_n ? 1'bx : so};
      #62.5 sclk = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    // released line shows the inverse of its last bit
    si = ~si;
    #100;
  endtask
endmodule // fcr_host

/* bench/fcr_config_checker.sv */
/*
  Assertion checker for the configuration register block.
  Assumes one mclk domain and the asynchronous active high reset.
*/
module fcr_config_checker #(
  parameter ADDR_W = 26
) (
  // clock and resets
  input wire mclk,
  input wire reset,
  input wire por,
  // serial link pins
  input wire sclk,
  input wire cs_n,
  input wire si,
  input wire so,
  input wire so_oe_n,
  // read engine
  input wire rd_start,
  input wire [31:0] rd_start_addr,
  input wire rd_next,
  input wire [ADDR_W-1:0] rd_addr,
  // decoded configuration
  input wire [3:0] dummy_cycles,
  input wire [2:0] execute_in_place_mode,
  input wire eip_enable,
  input wire [2:0] drive_sel,
  input wire dtr_enable,
  input wire data_line_three_func_en,
  input wire quad_enable,
  input wire dual_enable,
  input wire four_byte_addr,
  input wire [1:0] segment_sel,
  input wire [1:0] wrap_code
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // next address inside the wrap block, whole array for code 11
  function automatic [ADDR_W-1:0] wrap_next(input [1:0] w,
                                            input [ADDR_W-1:0] a);
    reg [ADDR_W-1:0] m;
    begin
      m = (w == 2'h3) ? {ADDR_W{1'b1}} : (6'h3f >> (2'h2 - w));
      wrap_next = (a & ~m) | ((a + 1'b1) & m);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  a_dummy_decoded: assert property (
    dummy_cycles != 4'h0 && dummy_cycles != 4'hf)
    else $error("dummy count not decoded");
  a_reload_eip: assert property (
    $fell(reset) |-> ##2 (eip_enable == (execute_in_place_mode != 3'h7)))
    else $error("execute in place not reloaded");
  a_drive_odd: assert property (drive_sel[0])
    else $error("reserved driver code shown");
  a_quad_wins: assert property (quad_enable |-> !dual_enable)
    else $error("quad and dual enabled together");
  a_start_three: assert property (
    rd_start && !four_byte_addr |=>
    rd_addr == {$past(segment_sel), $past(rd_start_addr[23:0])})
    else $error("three byte start address wrong");
  a_start_four: assert property (
    rd_start && four_byte_addr |=>
    rd_addr == $past(rd_start_addr[ADDR_W-1:0]))
    else $error("four byte start address wrong");
  a_oe_released: assert property (cs_n [*6] |-> so_oe_n)
    else $error("output enabled outside a frame");
  a_wrap_step: assert property (
    rd_next && !rd_start |=>
    rd_addr == wrap_next($past(wrap_code), $past(rd_addr)))
    else $error("read address step wrong");
  a_reset_values: assert property (disable iff (1'b0)
    reset |-> (wrap_code == 2'h3 && dummy_cycles == 4'h8 &&
    !eip_enable && so_oe_n))
    else $error("reset values wrong");

  // main scenarios reached
  c_wrap_sixteen: cover property (rd_next && wrap_code == 2'h0);
  c_read_data: cover property (!so_oe_n);
  c_quad_four: cover property (quad_enable && four_byte_addr);
endmodule // fcr_config_checker

bind fcr_config fcr_config_checker #(.ADDR_W(ADDR_W))
  fcr_config_checker_inst (
  .mclk(mclk), .reset(reset), .por(por), .sclk(sclk), .cs_n(cs_n),
  .si(si), .so(so), .so_oe_n(so_oe_n), .rd_start(rd_start),
  .rd_start_addr(rd_start_addr), .rd_next(rd_next), .rd_addr(rd_addr),
  .dummy_cycles(dummy_cycles), .execute_in_place_mode(execute_in_place_mode),
  .eip_enable(eip_enable), .drive_sel(drive_sel), .dtr_enable(dtr_enable),
  .data_line_three_func_en(data_line_three_func_en),
  .quad_enable(quad_enable), .dual_enable(dual_enable),
  .four_byte_addr(four_byte_addr), .segment_sel(segment_sel),
  .wrap_code(wrap_code));

/* bench/fcr_config_bench.sv */
/*
  Self-checking bench for the configuration register block.
  Assumes the host model on the link pins and fcr_map.vh on the path.
*/
`include "fcr_map.vh"

module fcr_config_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic mclk = 1'b0, reset = 1'b0, por = 1'b0;
  logic rd_start = 1'b0, rd_next = 1'b0;
  logic [31:0] rd_start_addr = 32'h0;
  logic [23:0] rx;
  wire sclk, cs_n, si, so, so_oe_n;
  wire [25:0] rd_addr;
  wire [3:0] dummy_cycles;
  wire [2:0] execute_in_place_mode, drive_sel;
  wire [1:0] segment_sel, wrap_code;
  wire eip_enable, dtr_enable, data_line_three_func_en, quad_enable;
  wire dual_enable, four_byte_addr;
  int n_errors = 0, cmp_count = 0;
  logic [25:0] wrap_exp [4] = '{26'h30, 26'h20, 26'h00, 26'h40};
  // all decoded outputs in one word for whole-set compares
  wire [19:0] cfg = {dummy_cycles, execute_in_place_mode, eip_enable,
    drive_sel, dtr_enable, data_line_three_func_en, quad_enable,
    dual_enable, four_byte_addr, segment_sel, wrap_code};

  always #5 mclk = ~mclk;

  fcr_config fcr_config_inst (.mclk(mclk), .reset(reset), .por(por),
    .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n),
    .rd_start(rd_start), .rd_start_addr(rd_start_addr), .rd_next(rd_next),
    .rd_addr(rd_addr), .dummy_cycles(dummy_cycles),
    .execute_in_place_mode(execute_in_place_mode), .eip_enable(eip_enable),
    .drive_sel(drive_sel), .dtr_enable(dtr_enable),
    .data_line_three_func_en(data_line_three_func_en),
    .quad_enable(quad_enable), .dual_enable(dual_enable),
    .four_byte_addr(four_byte_addr), .segment_sel(segment_sel),
    .wrap_code(wrap_code));
  fcr_host fcr_host_inst (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
    .so_oe_n(so_oe_n));

  //////////////////////////////////////////////////////////////////////
  task chk(input logic [25:0] got, input logic [25:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // por also clears the persistent register
  task pulse_reset(input logic p);
    @(posedge mclk);
    reset <= 1'b1;
    por <= p;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    por <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
  endtask

  // start, then two steps back to back
  task rd_go(input logic [31:0] a, input logic [25:0] e1, e2, e3);
    @(posedge mclk);
    rd_start <= 1'b1;
    rd_start_addr <= a;
    @(posedge mclk);
    rd_start <= 1'b0;
    rd_next <= 1'b1;
    #1 chk(rd_addr, e1, "start address");
    @(posedge mclk);
    #1 chk(rd_addr, e2, "first step");
    @(posedge mclk);
    rd_next <= 1'b0;
    #1 chk(rd_addr, e3, "second step");
  endtask

  //////////////////////////////////////////////////////////////////////
  task t_defaults();
    chk(cfg, 20'h8ee83, "power-on decode");
    fcr_host_inst.xfer(24, {`FCR_OP_RD_PERSIST, 16'h0}, rx);
    chk(rx[15:0], 16'hffff, "persistent reset");
    fcr_host_inst.xfer(16, {`FCR_OP_RD_RUNTIME, 8'h0}, rx);
    chk(rx[7:0], 8'hfb, "runtime reset");
  endtask

  // short write and unknown opcode leave everything alone
  task t_reject();
    logic [19:0] old;
    old = cfg;
    fcr_host_inst.xfer(15, {9'h0, `FCR_OP_WR_RUNTIME, 7'h0}, rx);
    fcr_host_inst.xfer(16, 16'h5a00, rx);
    chk(cfg, old, "refused frame");
  endtask

  task t_runtime();
    logic [7:0] b;
    logic [3:0] d;
    for (int i = 0; i < 16; i++) begin
      b = {i[3:0], i[0], 1'b1, i[1:0]};
      d = (i == 0 || i == 15) ? 4'h8 : i[3:0];
      fcr_host_inst.xfer(16, {`FCR_OP_WR_RUNTIME, b}, rx);
      chk(dummy_cycles, d, "runtime dummy");
      chk(!i[0], eip_enable, "runtime in place");
      chk(wrap_code, i[1:0], "runtime wrap");
      fcr_host_inst.xfer(16, {`FCR_OP_RD_RUNTIME, 8'h0}, rx);
      chk(rx[7:0], b & 8'hfb, "runtime readback");
      if (i < 4)
        rd_go(32'h3e, 26'h3e, 26'h3f, wrap_exp[i]);
    end
    pulse_reset(1'b0);
    chk(cfg, 20'h8ee83, "reset reload");
  endtask

  task t_persist(input logic [15:0] pc, input logic [19:0] ecfg,
                 input logic [31:0] a, input logic [25:0] e1);
    logic [19:0] old;
    old = cfg;
    fcr_host_inst.xfer(24, {`FCR_OP_WR_PERSIST, pc}, rx);
    chk(cfg, old, "persist write early");
    pulse_reset(1'b0);
    chk(cfg, ecfg, "persist decode");
    fcr_host_inst.xfer(24, {`FCR_OP_RD_PERSIST, 16'h0}, rx);
    chk(rx[15:0], pc, "persist readback");
    rd_go(a, e1, e1 + 26'h1, e1 + 26'h2);
  endtask

  task final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  // watchdog, between two and three times the expected run
  initial begin
    #400000;
    n_errors++;
    final_report();
  end

  initial begin
    logic [2:0] dv;
    // reset edge before the first clock, so no flop is seen unknown
    reset <= 1'b1;
    por <= 1'b1;
    pulse_reset(1'b1);
    t_defaults();
    t_reject();
    t_runtime();
    t_persist(16'h0440, 20'h8535f, 32'hfbff_fffe, 26'h3fffffe);
    t_persist(16'heffb, 20'heeea3, 32'hff12_3456, 26'h0123456);
    t_persist(16'hfffd, 20'h8ee8f, 32'h00ab_cdef, 26'h3abcdef);
    for (int d = 0; d < 8; d++) begin
      dv = d[0] ? d[2:0] : 3'h7;
      t_persist({7'h7f, d[2:0], 6'h3f}, {8'h8e, dv, 9'h083},
        32'h0, 26'h0);
    end
    final_report();
  end
endmodule // fcr_config_bench
